// ---- design/dac_digital_volume.sv ----
/*
DAC digital volume, soft-step and mute sequencer with a Wishbone register slave.
Assumes a 50 MHz mclk, synchronous reset, and samples from logic on the same clock.
*/
// Our own choices: the register offsets and the Wishbone register port.
// What this block does
// - Each DAC channel attenuates from 0 dB to -63.5 dB in 0.5 dB steps.
// - Each channel has its own mute bit independent of the other.
// - A master volume write sets both channels at once.
// - With soft-step on, applied gain moves one step per sample toward target.
// - A slow bit makes the gain step only every second sample.
// - A read-only done bit shows applied gain equals requested gain.
// - A control bit disables soft-step so changes apply immediately.
// - Power-down done flag sets only after ramp-down and power-down complete.
// - Any change to de-emphasis or effects selection is detected.
// - On such a change, ramp to mute, switch effects, then ramp back up.
// - At DAC power-up, volume starts muted and soft-steps up.
// - At DAC power-off, volume ramps to mute before circuitry powers down.
// - A register bit switches the whole stereo DAC on or off.
// - Each channel analog section has its own power control.
// - Each analog input level spans 0 dB to -12 dB in 1.5 dB steps.
// - Input level soft-steps follow the ADC gain soft-step settings.
`timescale 1ns/1ns
module dac_digital_volume #(
	parameter int SAMPLE_W = 24,
	parameter int FIFO_DEPTH = 8,
	parameter int NUM_INPUTS = 6,
	parameter int DIV = vol_pkg::FS_DIV
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [3:0] wbAdr,
	input wire logic [31:0] wbDatI,
	output logic [31:0] wbDatO,
	input wire logic [3:0] wbSel,
	input wire logic wbWe,
	input wire logic wbCyc,
	input wire logic wbStb,
	output logic wbAck,
	input wire logic inValid,
	input wire logic [2*SAMPLE_W-1:0] inData,
	output logic inReady,
	output logic outValid,
	output logic [2*SAMPLE_W-1:0] outData,
	input wire logic outReady,
	output logic dacPowerL,
	output logic dacPowerR,
	output logic [1:0] fxSelect,
	output logic [NUM_INPUTS*vol_pkg::LVL_W-1:0] inLevel
);
	localparam int AW = vol_pkg::ATT_W;
	localparam int LW = vol_pkg::LVL_W;

	sample_if #(.W(2*SAMPLE_W)) fin ();
	sample_if #(.W(2*SAMPLE_W)) fout ();

	logic [31:0] ctrl_q;
	logic [7:0] lVol_q;
	logic [7:0] rVol_q;
	logic [1:0] fxReq_q;
	logic [1:0] fxApplied_q;
	logic [NUM_INPUTS*LW-1:0] inLvlReq_q;
	logic [NUM_INPUTS*LW-1:0] inLvl_q;
	logic [AW:0] lGain_q;
	logic [AW:0] rGain_q;
	logic [AW:0] lTarget;
	logic [AW:0] rTarget;
	logic [15:0] div_q;
	logic tick;
	logic half_q;
	logic stepEn;
	logic pgaHalf_q;
	logic pgaStep;
	logic pdDone_q;
	logic ackHold_q;
	vol_pkg::seq_t seq_q;
	logic atMute;
	logic atTarget;
	logic forceMute;
	logic [2*SAMPLE_W-1:0] outData_d;

	// Gain code: 0..127 attenuation in half-dB, 128 stands for mute.
	function automatic logic [AW:0] stepToward(input logic [AW:0] cur, input logic [AW:0] tgt);
		if (cur < tgt)
			stepToward = cur + 1'b1;
		else if (cur > tgt)
			stepToward = cur - 1'b1;
		else
			stepToward = cur;
	endfunction

	function automatic logic signed [SAMPLE_W-1:0] scale(input logic signed [SAMPLE_W-1:0] s,
		input logic [AW:0] g);
		logic signed [SAMPLE_W+15:0] prod;
		logic [15:0] mant;
		logic [3:0] sh;
		prod = '0;
		mant = 16'h0000;
		sh = 4'h0;
		if (g[AW])
			scale = '0;
		else
		begin
			// A 6 dB shift per 12 codes plus a linear ratio keeps area small at the cost of accuracy.
			// The ratio starts at exactly one so that code 0 passes samples unchanged.
			sh = 4'(g / 12);
			mant = 16'(16'h8000 - 16'(16'h0555 * 16'(g % 12)));
			prod = (SAMPLE_W+16)'(s) * $signed({1'b0, mant});
			scale = SAMPLE_W'(prod >>> (15 + sh));
		end
	endfunction

	assign lTarget = lVol_q[vol_pkg::VOL_MUTE] ? {1'b1, {AW{1'b0}}} : {1'b0, lVol_q[AW-1:0]};
	assign rTarget = rVol_q[vol_pkg::VOL_MUTE] ? {1'b1, {AW{1'b0}}} : {1'b0, rVol_q[AW-1:0]};
	assign atMute = lGain_q[AW] && rGain_q[AW];
	assign atTarget = (lGain_q == lTarget) && (rGain_q == rTarget);
	assign forceMute = (seq_q == vol_pkg::SEQ_FXFALL) || (seq_q == vol_pkg::SEQ_FALL)
		|| (seq_q == vol_pkg::SEQ_OFF);

	// The divider stands in for the sample clock, so DIV sets the sample rate.
	always_ff @(posedge mclk)
	begin
		if (rst)
			div_q <= '0;
		else if (div_q == 16'(DIV - 1))
			div_q <= '0;
		else
			div_q <= div_q + 1'b1;
	end
	assign tick = (div_q == 16'(DIV - 1));

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			half_q <= 1'b0;
			pgaHalf_q <= 1'b0;
		end
		else if (tick)
		begin
			half_q <= ~half_q;
			pgaHalf_q <= ~pgaHalf_q;
		end
	end
	assign stepEn = tick && (!ctrl_q[vol_pkg::CTRL_SLOW] || half_q);
	assign pgaStep = tick && (!ctrl_q[vol_pkg::CTRL_PGASLOW] || pgaHalf_q);

	// Wishbone slave: one wait state, ack dropped the cycle after it is given.
	always_ff @(posedge mclk)
	begin
		if (rst)
			ackHold_q <= 1'b0;
		else
			ackHold_q <= wbCyc && wbStb && !ackHold_q;
	end
	assign wbAck = ackHold_q;

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			ctrl_q <= vol_pkg::CTRL_RESET;
			lVol_q <= 8'h00;
			rVol_q <= 8'h00;
			fxReq_q <= 2'h0;
			inLvlReq_q <= '0;
		end
		else if (wbCyc && wbStb && wbWe && ackHold_q && wbSel[0])
		begin
			if (wbAdr == vol_pkg::ADDR_CTRL)
				ctrl_q <= {25'h0000000, wbDatI[6:0]};
			else if (wbAdr == vol_pkg::ADDR_LVOL)
				lVol_q <= wbDatI[7:0];
			else if (wbAdr == vol_pkg::ADDR_RVOL)
				rVol_q <= wbDatI[7:0];
			else if (wbAdr == vol_pkg::ADDR_MVOL)
			begin
				lVol_q <= wbDatI[7:0];
				rVol_q <= wbDatI[7:0];
			end
			else if (wbAdr == vol_pkg::ADDR_FX)
				fxReq_q <= wbDatI[1:0];
			else if (wbAdr == vol_pkg::ADDR_INLVL)
			begin
				for (int i = 0; i < NUM_INPUTS; i++)
				begin
					if (wbDatI[i*LW +: LW] > vol_pkg::LVL_MAX)
						inLvlReq_q[i*LW +: LW] <= vol_pkg::LVL_MAX;
					else
						inLvlReq_q[i*LW +: LW] <= wbDatI[i*LW +: LW];
				end
			end
		end
	end

	always_comb
	begin
		wbDatO = 32'h00000000;
		if (wbAdr == vol_pkg::ADDR_CTRL)
			wbDatO = ctrl_q;
		else if (wbAdr == vol_pkg::ADDR_LVOL)
			wbDatO = {24'h000000, lVol_q};
		else if (wbAdr == vol_pkg::ADDR_RVOL)
			wbDatO = {24'h000000, rVol_q};
		else if (wbAdr == vol_pkg::ADDR_FX)
			wbDatO = {28'h0000000, fxApplied_q, fxReq_q};
		else if (wbAdr == vol_pkg::ADDR_STAT)
			wbDatO = {28'h0000000, dacPowerR, dacPowerL, pdDone_q, atTarget && !forceMute};
		else if (wbAdr == vol_pkg::ADDR_INLVL)
			wbDatO = 32'(inLvl_q);
		else if (wbAdr == vol_pkg::ADDR_APPLIED)
			// Left keeps only its upper seven bits so both codes fit below bit 15.
			wbDatO = {17'h00000, rGain_q, lGain_q[AW:1]};
	end

	// Sequencer for power-up, power-down and effects-change mute.
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			seq_q <= vol_pkg::SEQ_OFF;
			fxApplied_q <= 2'h0;
			pdDone_q <= 1'b1;
		end
		else
		begin
			case (seq_q)
				vol_pkg::SEQ_OFF:
					if (ctrl_q[vol_pkg::CTRL_DACON])
					begin
						seq_q <= vol_pkg::SEQ_RISE;
						pdDone_q <= 1'b0;
					end
				vol_pkg::SEQ_RISE, vol_pkg::SEQ_RUN:
					if (!ctrl_q[vol_pkg::CTRL_DACON])
						seq_q <= vol_pkg::SEQ_FALL;
					else if (fxReq_q != fxApplied_q)
						seq_q <= vol_pkg::SEQ_FXFALL;
					else
						seq_q <= vol_pkg::SEQ_RUN;
				vol_pkg::SEQ_FXFALL:
					if (atMute)
					begin
						fxApplied_q <= fxReq_q;
						seq_q <= vol_pkg::SEQ_RISE;
					end
				vol_pkg::SEQ_FALL:
					if (atMute)
					begin
						seq_q <= vol_pkg::SEQ_OFF;
						pdDone_q <= 1'b1;
					end
				default:
					seq_q <= vol_pkg::SEQ_OFF;
			endcase
		end
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			lGain_q <= {1'b1, {AW{1'b0}}};
			rGain_q <= {1'b1, {AW{1'b0}}};
		end
		else if (ctrl_q[vol_pkg::CTRL_SSOFF])
		begin
			lGain_q <= forceMute ? {1'b1, {AW{1'b0}}} : lTarget;
			rGain_q <= forceMute ? {1'b1, {AW{1'b0}}} : rTarget;
		end
		else if (stepEn)
		begin
			lGain_q <= stepToward(lGain_q, forceMute ? {1'b1, {AW{1'b0}}} : lTarget);
			rGain_q <= stepToward(rGain_q, forceMute ? {1'b1, {AW{1'b0}}} : rTarget);
		end
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
			inLvl_q <= '0;
		else
		begin
			for (int i = 0; i < NUM_INPUTS; i++)
			begin
				if (ctrl_q[vol_pkg::CTRL_PGASSOFF])
					inLvl_q[i*LW +: LW] <= inLvlReq_q[i*LW +: LW];
				else if (pgaStep)
				begin
					if (inLvl_q[i*LW +: LW] < inLvlReq_q[i*LW +: LW])
						inLvl_q[i*LW +: LW] <= inLvl_q[i*LW +: LW] + 1'b1;
					else if (inLvl_q[i*LW +: LW] > inLvlReq_q[i*LW +: LW])
						inLvl_q[i*LW +: LW] <= inLvl_q[i*LW +: LW] - 1'b1;
				end
			end
		end
	end
	assign inLevel = inLvl_q;

	// Analog power follows the sequencer so circuitry stays up while ramping down.
	assign dacPowerL = (seq_q != vol_pkg::SEQ_OFF) && ctrl_q[vol_pkg::CTRL_LPWR];
	assign dacPowerR = (seq_q != vol_pkg::SEQ_OFF) && ctrl_q[vol_pkg::CTRL_RPWR];
	assign fxSelect = fxApplied_q;

	assign fin.valid = inValid;
	assign fin.data = inData;
	assign inReady = fin.ready;

	sample_fifo #(.W(2*SAMPLE_W), .DEPTH(FIFO_DEPTH)) fifo (
		.mclk(mclk),
		.rst(rst),
		.inp(fin),
		.outp(fout)
	);

	assign outData_d = {scale(fout.data[2*SAMPLE_W-1:SAMPLE_W], rGain_q),
		scale(fout.data[SAMPLE_W-1:0], lGain_q)};
	// Output register is refilled only when empty or drained, so back-pressure reaches the FIFO.
	assign fout.ready = !outValid || outReady;

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			outValid <= 1'b0;
			outData <= '0;
		end
		else if (fout.ready)
		begin
			outValid <= fout.valid;
			outData <= outData_d;
		end
	end
endmodule

// ---- design/vol_pkg.sv ----
/*
Constants shared by the DAC digital volume and soft-step sequencer.
Assumes a single 50 MHz clock and a classic Wishbone register slave.
*/
package vol_pkg;
	localparam int ATT_W = 7;
	localparam int LVL_W = 4;
	localparam logic [ATT_W-1:0] ATT_ZERO = 7'h00;
	localparam logic [ATT_W-1:0] ATT_MAX = 7'h7f;
	localparam logic [LVL_W-1:0] LVL_MAX = 4'h8;
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_LVOL = 4'h1;
	localparam logic [3:0] ADDR_RVOL = 4'h2;
	localparam logic [3:0] ADDR_MVOL = 4'h3;
	localparam logic [3:0] ADDR_FX = 4'h4;
	localparam logic [3:0] ADDR_STAT = 4'h5;
	localparam logic [3:0] ADDR_INLVL = 4'h6;
	localparam logic [3:0] ADDR_APPLIED = 4'h7;
	localparam int CTRL_DACON = 0;
	localparam int CTRL_LPWR = 1;
	localparam int CTRL_RPWR = 2;
	localparam int CTRL_SSOFF = 3;
	localparam int CTRL_SLOW = 4;
	localparam int CTRL_PGASSOFF = 5;
	localparam int CTRL_PGASLOW = 6;
	localparam int VOL_MUTE = 7;
	localparam logic [31:0] CTRL_RESET = 32'h00000006;
	localparam int STAT_DONE = 0;
	localparam int STAT_PDDONE = 1;
	localparam int STAT_LPWR = 2;
	localparam int STAT_RPWR = 3;
	localparam int FS_HZ = 48000;
	localparam int CLK_HZ = 50000000;
	localparam int FS_DIV = CLK_HZ / FS_HZ;
	typedef enum logic [2:0] {SEQ_OFF, SEQ_RISE, SEQ_RUN, SEQ_FXFALL, SEQ_FALL} seq_t;
endpackage

// ---- design/sample_if.sv ----
/*
Interface carrying stereo samples between the volume block and its FIFO.
Assumes both ends sit on the one clock.
*/
`timescale 1ns/1ns
interface sample_if #(parameter int W = 48);
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

// ---- design/sample_fifo.sv ----
/*
Synchronous FIFO with valid and ready on both sides.
Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ns
module sample_fifo #(
	parameter int W = 48,
	parameter int DEPTH = 8
) (
	input wire logic mclk,
	input wire logic rst,
	sample_if.snk inp,
	sample_if.src outp
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wrPtr_q;
	logic [AW-1:0] rdPtr_q;
	logic [AW:0] count_q;
	logic push;
	logic pop;

	assign inp.ready = (count_q != (AW+1)'(DEPTH));
	assign outp.valid = (count_q != '0);
	assign outp.data = mem[rdPtr_q];
	assign push = inp.valid && inp.ready;
	assign pop = outp.valid && outp.ready;

	always_ff @(posedge mclk)
	begin
		if (push)
		begin
			mem[wrPtr_q] <= inp.data;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			count_q <= '0;
		end
		else
		begin
			if (push)
			begin
				wrPtr_q <= (wrPtr_q == AW'(DEPTH-1)) ? '0 : wrPtr_q + 1'b1;
			end
			if (pop)
			begin
				rdPtr_q <= (rdPtr_q == AW'(DEPTH-1)) ? '0 : rdPtr_q + 1'b1;
			end
			count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// ---- tb/sample_sink.sv ----
/* Far-side sample sink: takes output words, stalls on request. Assumes mclk. */
`timescale 1ns/1ns
module sample_sink (
	input wire logic mclk,
	input wire logic rst,
	input wire logic stall,
	output logic outReady
);
	// Ready is registered so a stall lands one edge after it is asked for.
	always_ff @(posedge mclk)
	begin
		outReady <= !rst && !stall;
	end
endmodule

// ---- tb/dac_digital_volume_assertions.sv ----
/* Port assertions for the volume block. Assumes the bind below. */
`timescale 1ns/1ns
module dac_digital_volume_assertions #(
	parameter int SAMPLE_W = 24,
	parameter int NUM_INPUTS = 6
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [3:0] wbAdr,
	input wire logic [31:0] wbDatO,
	input wire logic wbWe,
	input wire logic wbCyc,
	input wire logic wbStb,
	input wire logic wbAck,
	input wire logic inReady,
	input wire logic outValid,
	input wire logic [2*SAMPLE_W-1:0] outData,
	input wire logic outReady,
	input wire logic dacPowerL,
	input wire logic dacPowerR,
	input wire logic [1:0] fxSelect,
	input wire logic [NUM_INPUTS*vol_pkg::LVL_W-1:0] inLevel
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);
	sequence reqStart;
		$rose(wbCyc && wbStb);
	endsequence
	sequence ackOnce;
		wbAck ##1 !wbAck;
	endsequence
	AST_ACK_LATE: assert property (reqStart |=> ackOnce)
		else $error("ack late or long");
	AST_ACK_HELD: assert property (wbAck |-> wbCyc && wbStb)
		else $error("ack without request");
	AST_UNMAPPED: assert property (wbAck && !wbWe && wbAdr[3] |-> wbDatO == 32'h0)
		else $error("unmapped read not zero");
	AST_OUT_HOLD: assert property (outValid && !outReady |=> outValid && $stable(outData))
		else $error("held sample lost");
	AST_RESET: assert property ($fell(rst) |-> inReady && !outValid && !wbAck)
		else $error("stream busy after reset");
	AST_PWR_RESET: assert property ($fell(rst) |-> !dacPowerL && !dacPowerR && fxSelect == 2'h0)
		else $error("power up after reset");
	AST_LVL_LOW: assert property (inLevel[3:0] <= vol_pkg::LVL_MAX)
		else $error("first level too big");
	AST_LVL_HIGH: assert property (inLevel[NUM_INPUTS*4-1 -: 4] <= vol_pkg::LVL_MAX)
		else $error("last level too big");
endmodule
bind dac_digital_volume dac_digital_volume_assertions #(.SAMPLE_W(SAMPLE_W),
	.NUM_INPUTS(NUM_INPUTS)) u_chk (.mclk, .rst, .wbAdr, .wbDatO, .wbWe, .wbCyc, .wbStb,
	.wbAck, .inReady, .outValid, .outData, .outReady, .dacPowerL, .dacPowerR, .fxSelect,
	.inLevel);

// ---- tb/tb_dac_digital_volume.sv ----
/* Bench for the volume block with a sample model. Assumes the sink model. */
`timescale 1ns/1ns
module tb_dac_digital_volume;
	localparam int D = 4;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] wbAdr = 4'h0;
	logic [31:0] wbDatI = 32'h0;
	logic wbWe = 1'b0;
	logic wbCyc = 1'b0;
	logic wbStb = 1'b0;
	logic inValid = 1'b0;
	logic [47:0] inData = 48'h0;
	logic stall = 1'b0;
	logic [3:0] wbSel = 4'h0;
	logic [3:0] useSel = 4'hf;
	logic [31:0] wbDatO, rd;
	logic [47:0] outData, v;
	logic wbAck, inReady, outValid, outReady, dacPowerL, dacPowerR;
	logic [1:0] fxSelect;
	logic [23:0] inLevel;
	logic [47:0] q[$];
	int fail_count = 0;
	int cmp_count = 0;
	int cyc = 0;
	int n;
	bit lm = 1'b0;
	bit rm = 1'b0;
	// A short sample tick keeps every ramp within a few thousand cycles.
	dac_digital_volume #(.DIV(D)) u_dut (.mclk, .rst, .wbAdr, .wbDatI, .wbDatO, .wbSel,
		.wbWe, .wbCyc, .wbStb, .wbAck, .inValid, .inData, .inReady, .outValid, .outData,
		.outReady, .dacPowerL, .dacPowerR, .fxSelect, .inLevel);
	sample_sink u_sink (.mclk, .rst, .stall, .outReady);
	initial
	begin
		forever #10 mclk = ~mclk;
	end
	task automatic chk(string s, logic [47:0] e, logic [47:0] g);
		cmp_count++;
		if (g !== e)
		begin
			fail_count++;
			$display("Error %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic end_of_test();
		if (fail_count == 0 && cmp_count > 0)
		begin
			$display("Result: passed");
		end
		else
		begin
			$display("Result: failed");
		end
		$finish;
	endtask
	always @(posedge mclk)
	begin
		cyc <= cyc + 1;
		if (outValid === 1'b1 && outReady === 1'b1)
		begin
			chk("outData", q.pop_front(), outData);
		end
		if (cyc == 30000)
		begin
			fail_count++;
			end_of_test();
		end
	end
	task automatic wb(logic [3:0] a, logic w, logic [31:0] d);
		wbAdr <= a;
		wbWe <= w;
		wbDatI <= d;
		wbSel <= useSel;
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		do @(posedge mclk); while (wbAck !== 1'b1);
		rd = wbDatO;
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic waitStat(int b, output int t);
		int c0;
		c0 = cyc;
		wb(vol_pkg::ADDR_STAT, 1'b0, 32'h0);
		for (int i = 0; i < 4000 && rd[b] !== 1'b1; i++)
		begin
			wb(vol_pkg::ADDR_STAT, 1'b0, 32'h0);
		end
		t = cyc - c0;
	endtask
	task automatic send(int k);
		repeat (k)
		begin
			v = 48'({$urandom, $urandom});
			inValid <= 1'b1;
			inData <= v;
			do @(posedge mclk); while (inReady !== 1'b1);
			q.push_back({rm ? 24'h0 : v[47:24], lm ? 24'h0 : v[23:0]});
		end
		inValid <= 1'b0;
		@(posedge mclk);
	endtask
	initial
	begin
		n = $urandom(1);
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		wb(vol_pkg::ADDR_CTRL, 1'b0, 32'h0);
		chk("ctrl", vol_pkg::CTRL_RESET, rd);
		wb(vol_pkg::ADDR_STAT, 1'b0, 32'h0);
		chk("pdDone", 1, rd[vol_pkg::STAT_PDDONE]);
		wb(4'h9, 1'b1, 32'hffffffff);
		wb(4'h9, 1'b0, 32'h0);
		chk("unmapped", 0, rd);
		useSel = 4'he;
		wb(vol_pkg::ADDR_LVOL, 1'b1, 32'h55);
		useSel = 4'hf;
		wb(vol_pkg::ADDR_LVOL, 1'b0, 32'h0);
		chk("selOff", 0, rd);
		wb(vol_pkg::ADDR_LVOL, 1'b1, 32'h0);
		wb(vol_pkg::ADDR_CTRL, 1'b1, 32'h07);
		waitStat(vol_pkg::STAT_DONE, n);
		chk("rampUp", 1, n >= 126 * D && n <= 130 * D + 8);
		send(4);
		wb(vol_pkg::ADDR_CTRL, 1'b1, 32'h17);
		wb(vol_pkg::ADDR_LVOL, 1'b1, 32'h08);
		waitStat(vol_pkg::STAT_DONE, n);
		chk("slowRamp", 1, n >= 6 * 2 * D && n <= 10 * 2 * D + 8);
		wb(vol_pkg::ADDR_CTRL, 1'b1, 32'h0f);
		wb(vol_pkg::ADDR_LVOL, 1'b1, 32'h80);
		wb(vol_pkg::ADDR_STAT, 1'b0, 32'h0);
		chk("instant", 1, rd[vol_pkg::STAT_DONE]);
		lm = 1'b1;
		send(3);
		wb(vol_pkg::ADDR_MVOL, 1'b1, 32'h85);
		wb(vol_pkg::ADDR_RVOL, 1'b0, 32'h0);
		chk("rvol", 32'h85, rd);
		wb(vol_pkg::ADDR_APPLIED, 1'b0, 32'h0);
		chk("applied", 32'h4040, rd);
		rm = 1'b1;
		send(2);
		wb(vol_pkg::ADDR_MVOL, 1'b1, 32'h0);
		lm = 1'b0;
		rm = 1'b0;
		// The sink stalls so the buffer fills until it refuses.
		stall <= 1'b1;
		n = 0;
		v = 48'({$urandom, $urandom});
		inValid <= 1'b1;
		inData <= v;
		repeat (14)
		begin
			@(posedge mclk);
			if (inReady === 1'b1)
			begin
				n++;
				q.push_back(v);
				v = 48'({$urandom, $urandom});
				inData <= v;
			end
		end
		chk("filled", 1, n == 8 || n == 9);
		stall <= 1'b0;
		do @(posedge mclk); while (inReady !== 1'b1);
		q.push_back(v);
		inValid <= 1'b0;
		repeat (30) @(posedge mclk);
		chk("drained", 0, q.size());
		wb(vol_pkg::ADDR_CTRL, 1'b1, 32'h07);
		wb(vol_pkg::ADDR_FX, 1'b1, 32'h1);
		chk("fxEarly", 0, fxSelect);
		waitStat(vol_pkg::STAT_DONE, n);
		chk("fxRamp", 1, n >= 250 * D && n <= 260 * D + 8);
		chk("fxLate", 1, fxSelect);
		wb(vol_pkg::ADDR_CTRL, 1'b1, 32'h06);
		chk("hold", 3, {dacPowerL, dacPowerR});
		waitStat(vol_pkg::STAT_PDDONE, n);
		chk("pdRamp", 1, n >= 126 * D);
		chk("off", 0, {dacPowerL, dacPowerR});
		wb(vol_pkg::ADDR_CTRL, 1'b1, 32'h43);
		// The sequencer leaves its off state one edge after the write.
		repeat (2) @(posedge mclk);
		chk("mono", 2, {dacPowerL, dacPowerR});
		// Slow input stepping moves one code every second sample tick.
		wb(vol_pkg::ADDR_INLVL, 1'b1, 32'h812345);
		repeat (4 * D) @(posedge mclk);
		chk("lvlStep", 2, inLevel[23:20]);
		for (int i = 0; i < 400 && inLevel !== 24'h812345; i++)
		begin
			@(posedge mclk);
		end
		chk("inLevel", 48'h812345, inLevel);
		end_of_test();
	end
endmodule
